// file: logic/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// length of the serial shift chain, control bit not included
`define SCP_CHAIN_LEN      32

// field positions inside the shift chain (bit 0 is the stage next to the control bit)
`define SCP_A_LSB          0
`define SCP_A_MSB          6
`define SCP_N_LSB          7
`define SCP_N_MSB          16
`define SCP_R_LSB          17
`define SCP_R_MSB          30

// reset values of the counter latches and the chain
`define SCP_A_RST          7'h00
`define SCP_N_RST          10'h000
`define SCP_R_RST          14'h0000
`define SCP_CHAIN_RST      32'h0000_0000

// stages of every pin synchroniser
`define SCP_SYNC_STAGES    2

`endif

// file: logic/scp_pkg.sv
package scp_pkg;

    // where the reference counter takes its clock from
    typedef enum logic {
        SCP_SRC_OSCILLATOR,
        SCP_SRC_EXTERNAL
    } scp_ref_source_type;

    // which counter latch a strobe may load
    typedef struct packed {
        logic load_na;
        logic load_r;
    } scp_load_type;

endpackage

// file: logic/scp_dual_modulus.sv
`timescale 1ns/1ps
`default_nettype none

module scp_dual_modulus #(
    parameter int N_WIDTH = 10,
    parameter int A_WIDTH = 7
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // one-cycle pulse per prescaler rising edge
    input  wire logic               advance,
    // programmed values from the latches
    input  wire logic [N_WIDTH-1:0] n_value,
    input  wire logic [A_WIDTH-1:0] a_value,
    // modulus control and end of cycle
    output logic                    modulus_select,
    output logic                    cycle_done
);
    import scp_pkg::*;

    logic [N_WIDTH-1:0] n_cnt_reg;   // remaining edges of the whole cycle
    logic [A_WIDTH-1:0] a_cnt_reg;   // remaining edges at low modulus
    logic               mc_reg;      // modulus select
    logic               done_reg;    // end-of-cycle pulse
    logic               n_last;      // this edge ends the cycle

    // a count of zero (after reset or with n programmed to zero) reloads at once
    assign n_last = (n_cnt_reg <= N_WIDTH'(1));

    // divide-by-n counter, reloads on the edge that finds it at one
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            n_cnt_reg <= '0;
        end else if (advance) begin
            if (n_last) begin
                n_cnt_reg <= n_value;                       // [RULE12]
            end else begin
                n_cnt_reg <= n_cnt_reg - N_WIDTH'(1);        // [RULE1]
            end
        end
    end

    // divide-by-a counter, stops at zero until the cycle ends
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            a_cnt_reg <= '0;
        end else if (advance) begin
            if (n_last) begin
                a_cnt_reg <= a_value;                       // [RULE12]
            end else if (a_cnt_reg != '0) begin
                a_cnt_reg <= a_cnt_reg - A_WIDTH'(1);        // [RULE1]
            end
        end
    end

    // modulus select: low until a hits zero, high until n hits zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mc_reg <= 1'h0;
        end else if (advance) begin
            if (n_last) begin
                // a programmed zero means no low-modulus part at all
                mc_reg <= (a_value == '0);                  // [RULE12]
            end else if (a_cnt_reg == A_WIDTH'(1)) begin
                mc_reg <= 1'h1;                             // [RULE12]
            end
        end
    end

    // one pulse per completed count cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            done_reg <= 1'h0;
        end else begin
            done_reg <= advance & n_last;
        end
    end

    assign modulus_select = mc_reg;
    assign cycle_done     = done_reg;

endmodule

`default_nettype wire

// file: logic/scp_port.sv
// What this block does
// RULE1 - prescaler rising edges advance n and a
// RULE2 - serial clock rising edge shifts data in
// RULE3 - last shifted bit sits in control register
// RULE4 - control one plus strobe loads reference latch
// RULE5 - control zero keeps reference latch unchanged
// RULE6 - strobe always loads the n/a latch
// RULE7 - latches follow the chain while strobe high
// RULE8 - strobe low freezes all programmed values
// RULE9 - host pulses strobe briefly after shifting
// RULE10 - reference from oscillator or external input
// RULE11 - chain output is true last stage, unlatched
// RULE12 - modulus select low, high, reload sequence
// RULE13 - fixed field layout of serial word
// RULE14 - latching leaves the shift chain untouched
`timescale 1ns/1ps
`default_nettype none

`include "scp_defs.svh"

module scp_port #(
    parameter int N_WIDTH   = 10,
    parameter int A_WIDTH   = 7,
    parameter int R_WIDTH   = 14,
    parameter int CHAIN_LEN = `SCP_CHAIN_LEN
) (
    // system clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    // serial programming link, clocked by the host
    input  wire logic                        serial_clk,
    input  wire logic                        serial_data,
    input  wire logic                        latch_strobe,
    output logic                             shift_chain_output,
    // counter clock inputs
    input  wire logic                        prescaler_input,
    input  wire logic                        reference_input,
    input  wire scp_pkg::scp_ref_source_type ref_source,
    // prescaler and oscillator drive
    output logic                             modulus_select,
    output logic                             oscillator_drive_output,
    // divided frequencies, one-cycle pulses
    output logic                             vco_divided_pulse,
    output logic                             ref_divided_pulse,
    // programmed values as seen by the counters
    output logic [N_WIDTH-1:0]               n_latch_value,
    output logic [A_WIDTH-1:0]               a_latch_value,
    output logic [R_WIDTH-1:0]               r_latch_value,
    output logic                             control_bit_value
);
    import scp_pkg::*;

    // ---------------- serial clock domain ----------------

    logic                 srst_meta_reg;   // reset crossing, first stage
    logic                 srst_reg;        // reset in the serial domain
    logic                 ctrl_reg;        // one-bit control register
    logic [CHAIN_LEN-1:0] chain_reg;       // shift chain behind the control bit

    // sys_rst brought over as a level; only acts while the host clocks.
    // the chain needs no reset to work: a full word of 33 shifts
    // overwrites every stage, so a serial clock that never runs in
    // reset is harmless
    always_ff @(posedge serial_clk) begin
        srst_meta_reg <= sys_rst;
        srst_reg      <= srst_meta_reg;
    end

    // control bit takes the newest bit, so the last bit of a word ends here;
    // the system domain reads it too, but only while the synchronised
    // strobe is high, when the host has stopped clocking
    always_ff @(posedge serial_clk) begin
        if (srst_reg) begin
            // reset only lands once the host has clocked three times
            ctrl_reg <= 1'h0;
        end else begin
            ctrl_reg <= serial_data;                        // [RULE2] [RULE3]
        end
    end

    // older bits move one stage down the chain on each rising edge
    always_ff @(posedge serial_clk) begin
        if (srst_reg) begin
            chain_reg <= CHAIN_LEN'(`SCP_CHAIN_RST);
        end else begin
            // the control bit feeds stage zero, so 33 shifts fill both
            // no strobe term here: latching never clears the chain
            chain_reg <= {chain_reg[CHAIN_LEN-2:0], ctrl_reg}; // [RULE2] [RULE14]
        end
    end

    // ---------------- pin synchronisers in the system domain ----------------

    logic [`SCP_SYNC_STAGES-1:0] strobe_sync_reg;  // latch strobe
    logic [`SCP_SYNC_STAGES-1:0] fin_sync_reg;     // prescaler input
    logic [`SCP_SYNC_STAGES-1:0] ref_sync_reg;     // reference input
    logic [`SCP_SYNC_STAGES-1:0] sro_sync_reg;     // last chain stage
    logic                        fin_prev_reg;     // for edge detection
    logic                        ref_prev_reg;     // for edge detection
    logic                        strobe_level;     // synchronised strobe
    logic                        fin_rise;         // prescaler rising edge
    logic                        ref_rise;         // reference rising edge

    // two stages each; only the second stage is read by any logic.
    // the strobe and both counting pins are asynchronous to clk_sys and
    // the chain end moves on serial_clk, so any first stage may go
    // metastable; the price is two cycles of latency on every pin
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strobe_sync_reg <= '0;
            fin_sync_reg    <= '0;
            ref_sync_reg    <= '0;
            sro_sync_reg    <= '0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[0], latch_strobe};
            fin_sync_reg    <= {fin_sync_reg[0], prescaler_input};
            ref_sync_reg    <= {ref_sync_reg[0], reference_input};
            sro_sync_reg    <= {sro_sync_reg[0], chain_reg[CHAIN_LEN-1]};
        end
    end

    // previous synchronised levels for rising-edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // both pins idle low, so no false edge follows reset
            fin_prev_reg <= 1'h0;
            ref_prev_reg <= 1'h0;
        end else begin
            fin_prev_reg <= fin_sync_reg[1];
            ref_prev_reg <= ref_sync_reg[1];
        end
    end

    // a pin must stay high and low for two clk_sys cycles each, or an
    // edge is lost; the counting inputs are therefore limited to well
    // below a quarter of the system clock
    assign strobe_level = strobe_sync_reg[1];
    assign fin_rise     = fin_sync_reg[1] & ~fin_prev_reg;  // [RULE1]
    assign ref_rise     = ref_sync_reg[1] & ~ref_prev_reg;

    // ---------------- counter latches ----------------

    // the chain is quasi-static while the strobe is high: the host does not
    // clock during the pulse, so the strobe level qualifies the word crossing;
    // a host that shifts while the strobe is high corrupts the latched values,
    // so the strobe must stay high for three clk_sys cycles and low for
    // three more before the next serial edge
    // decoded once so both latch processes see the same window
    scp_load_type         load;            // which latches load this cycle
    logic [N_WIDTH-1:0]   n_latch_reg;     // divide-by-n programming
    logic [A_WIDTH-1:0]   a_latch_reg;     // divide-by-a programming
    logic [R_WIDTH-1:0]   r_latch_reg;     // reference programming
    logic                 ctrl_seen_reg;   // control bit as last latched

    // strobe high makes the n/a latches transparent, the reference latch only with control one; low holds them
    always_comb begin
        load.load_na = strobe_level;                        // [RULE6] [RULE7] [RULE8]
        load.load_r  = strobe_level & ctrl_reg;             // [RULE4] [RULE5]
    end

    // n and a load whatever the control bit says
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            n_latch_reg <= N_WIDTH'(`SCP_N_RST);
            a_latch_reg <= A_WIDTH'(`SCP_A_RST);
        end else if (load.load_na) begin
            // loaded on every cycle of the window; the chain is still then
            n_latch_reg <= N_WIDTH'(chain_reg[`SCP_N_MSB:`SCP_N_LSB]); // [RULE13] [RULE6]
            a_latch_reg <= A_WIDTH'(chain_reg[`SCP_A_MSB:`SCP_A_LSB]); // [RULE13] [RULE6]
        end
    end

    // reference latch only when the control bit is one
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_latch_reg <= R_WIDTH'(`SCP_R_RST);
        end else if (load.load_r) begin
            // same transparent window as n and a, gated by the control bit
            r_latch_reg <= R_WIDTH'(chain_reg[`SCP_R_MSB:`SCP_R_LSB]); // [RULE4] [RULE13]
        end
        // control bit zero: the latch simply keeps its value [RULE5]
    end

    // control bit seen at the last transparent cycle, for observation
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_seen_reg <= 1'h0;
        end else if (load.load_na) begin
            ctrl_seen_reg <= ctrl_reg;                      // [RULE3]
        end
    end

    // ---------------- divide-by-n / divide-by-a ----------------

    // the counters only see prescaler output edges; the divide ratio of
    // the prescaler itself never enters this block
    logic mc_int;      // modulus select from the counter
    logic vco_done;    // end of a dual-modulus cycle

    scp_dual_modulus #(
        .N_WIDTH (N_WIDTH),
        .A_WIDTH (A_WIDTH)
    ) scp_dual_modulus_i (
        .clk_sys        (clk_sys),
        .sys_rst        (sys_rst),
        .advance        (fin_rise),                         // [RULE1]
        .n_value        (n_latch_reg),
        .a_value        (a_latch_reg),
        .modulus_select (mc_int),                           // [RULE12]
        .cycle_done     (vco_done)
    );

    // ---------------- reference counter ----------------

    logic [R_WIDTH-1:0] r_cnt_reg;      // remaining reference edges
    logic               r_last;         // this edge ends the period
    logic               ref_done_reg;   // divided reference pulse
    logic               osc_drive_reg;  // oscillator amplifier output

    // a period of r edges: count down to one, then reload; a programmed
    // value of zero or one gives a pulse on every reference edge
    // zero after reset or programming zero reloads on the next edge
    assign r_last = (r_cnt_reg <= R_WIDTH'(1));

    // both sources arrive on reference_input; the amplifier only adds drive
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_cnt_reg <= '0;
        end else if (ref_rise) begin                        // [RULE10]
            if (r_last) begin
                // a new latch value only takes effect at the period boundary
                r_cnt_reg <= r_latch_reg;
            end else begin
                r_cnt_reg <= r_cnt_reg - R_WIDTH'(1);
            end
        end
    end

    // one pulse per divided reference period
    // registered here, so it already comes straight from a flop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ref_done_reg <= 1'h0;
        end else begin
            ref_done_reg <= ref_rise & r_last;
        end
    end

    // inverting amplifier in oscillator mode, quiet in external mode
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            osc_drive_reg <= 1'h0;
        end else begin
            case (ref_source)
                SCP_SRC_OSCILLATOR: begin
                    // digital inverter; the crystal loop itself is analog
                    osc_drive_reg <= ~ref_sync_reg[1];      // [RULE10]
                end
                SCP_SRC_EXTERNAL: begin
                    // nothing needs driving when a reference is applied
                    osc_drive_reg <= 1'h0;                  // [RULE10]
                end
                default: begin
                    // unreachable for a one-bit source, kept quiet anyway
                    osc_drive_reg <= 1'h0;
                end
            endcase
        end
    end

    // ---------------- output registers ----------------

    logic mc_out_reg;    // modulus select to the prescaler
    logic vco_out_reg;   // divided prescaler pulse

    // extra stage keeps every output straight from a flop,
    // at the cost of one more cycle between a counting edge and the select
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mc_out_reg  <= 1'h0;
            vco_out_reg <= 1'h0;
        end else begin
            mc_out_reg  <= mc_int;                          // [RULE12]
            vco_out_reg <= vco_done;
        end
    end

    // the chain output is the true last stage, never held by the strobe;
    // it is brought into the system domain so it is defined from reset;
    // the price is a lag of one to two clk_sys cycles behind the shift
    assign shift_chain_output      = sro_sync_reg[1];       // [RULE11]
    assign modulus_select          = mc_out_reg;
    assign oscillator_drive_output = osc_drive_reg;
    assign vco_divided_pulse       = vco_out_reg;
    assign ref_divided_pulse       = ref_done_reg;
    assign n_latch_value           = n_latch_reg;
    assign a_latch_value           = a_latch_reg;
    assign r_latch_value           = r_latch_reg;
    assign control_bit_value       = ctrl_seen_reg;

endmodule

`default_nettype wire

// file: testbench/scp_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module scp_port_assertions #(
    parameter int N_WIDTH = 10,
    parameter int A_WIDTH = 7,
    parameter int R_WIDTH = 14
) (
    // clock and reset
    input wire logic                        clk_sys,
    input wire logic                        sys_rst,
    // pins
    input wire logic                        latch_strobe,
    input wire logic                        prescaler_input,
    input wire logic                        reference_input,
    input wire scp_pkg::scp_ref_source_type ref_source,
    // outputs
    input wire logic                        modulus_select,
    input wire logic                        oscillator_drive_output,
    input wire logic                        vco_divided_pulse,
    input wire logic                        ref_divided_pulse,
    input wire logic [N_WIDTH-1:0]          n_latch_value,
    input wire logic [A_WIDTH-1:0]          a_latch_value,
    input wire logic [R_WIDTH-1:0]          r_latch_value,
    input wire logic                        control_bit_value
);
    import scp_pkg::*;

    logic [3:0] pre_age; // cycles since prescaler rise
    logic [3:0] ref_age; // cycles since reference rise
    logic [3:0] str_age; // cycles since strobe high
    logic       pre_q;   // last prescaler sample
    logic       ref_q;   // last reference sample

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ages saturate at 15 so a quiet pin never wraps back into range
    always_ff @(posedge clk_sys) begin
        pre_q <= prescaler_input;
        ref_q <= reference_input;
        if (sys_rst) begin
            pre_age <= 4'hf;
            ref_age <= 4'hf;
            str_age <= 4'hf;
        end else begin
            pre_age <= (prescaler_input && !pre_q) ? 4'h0 : pre_age + 4'(pre_age != 4'hf);
            ref_age <= (reference_input && !ref_q) ? 4'h0 : ref_age + 4'(ref_age != 4'hf);
            str_age <= latch_strobe ? 4'h0 : str_age + 4'(str_age != 4'hf);
        end
    end

    a_latch_hold_low: assert property (
        !latch_strobe && !$past(latch_strobe) && !$past(latch_strobe, 2)
        |=> $stable({n_latch_value, a_latch_value, r_latch_value, control_bit_value}))
        else $error("latch moved with strobe low");
    a_latch_needs_strobe: assert property (
        $changed({n_latch_value, a_latch_value, r_latch_value}) |-> str_age <= 4'h4)
        else $error("latch moved long after strobe");
    a_ref_needs_ctrl: assert property (
        $changed(r_latch_value) |-> control_bit_value)
        else $error("reference latch loaded with control zero");
    a_vco_pulse_once: assert property (
        vco_divided_pulse |=> !vco_divided_pulse)
        else $error("vco pulse longer than one cycle");
    a_ref_pulse_once: assert property (
        ref_divided_pulse |=> !ref_divided_pulse)
        else $error("ref pulse longer than one cycle");
    a_select_after_edge: assert property (
        $changed(modulus_select) |-> pre_age <= 4'h8)
        else $error("select moved without prescaler edge");
    a_vco_after_edge: assert property (
        vco_divided_pulse |-> pre_age <= 4'h8)
        else $error("vco pulse without prescaler edge");
    a_ref_after_edge: assert property (
        ref_divided_pulse |-> ref_age <= 4'h8)
        else $error("ref pulse without reference edge");
    a_osc_ext_low: assert property (
        ref_source == SCP_SRC_EXTERNAL && $past(ref_source) == SCP_SRC_EXTERNAL
        && $past(ref_source, 2) == SCP_SRC_EXTERNAL |=> !oscillator_drive_output)
        else $error("oscillator drive active in external mode");
endmodule

bind scp_port scp_port_assertions #(
    .N_WIDTH(N_WIDTH), .A_WIDTH(A_WIDTH), .R_WIDTH(R_WIDTH)
) scp_port_assertions_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .latch_strobe(latch_strobe),
    .prescaler_input(prescaler_input), .reference_input(reference_input),
    .ref_source(ref_source), .modulus_select(modulus_select),
    .oscillator_drive_output(oscillator_drive_output),
    .vco_divided_pulse(vco_divided_pulse), .ref_divided_pulse(ref_divided_pulse),
    .n_latch_value(n_latch_value), .a_latch_value(a_latch_value),
    .r_latch_value(r_latch_value), .control_bit_value(control_bit_value)
);

`default_nettype wire

// file: testbench/scp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
    // serial pins toward the port
    output logic serial_clk,
    output logic serial_data,
    output logic latch_strobe
);
    // link clock idles low, strobe kept normally low
    initial begin
        serial_clk = 1'h0;
        serial_data = 1'h0;
        latch_strobe = 1'h0;
    end

    // chain bit 31 goes first, control bit last
    task automatic send_frame(input logic [31:0] word, input logic ctrl);
        logic [32:0] bits;
        bits = {word, ctrl};
        for (int i = 32; i >= 0; i--) begin
            serial_data = bits[i];
            #7.5 serial_clk = 1'h1;
            #7.5 serial_clk = 1'h0;
        end
        // released line shows no stale level
        #7.5 serial_data = ~bits[0];
    endtask

    // one brief pulse, long enough for the synchroniser
    task automatic pulse_strobe();
        #22 latch_strobe = 1'h1;
        #50 latch_strobe = 1'h0;
        #48;
    endtask
endmodule

`default_nettype wire

// file: testbench/scp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module scp_port_tb;
    import scp_pkg::*;

    localparam logic [6:0] A_VAL = 7'h02;  // short a phase
    localparam logic [9:0] N_VAL = 10'h005;
    localparam logic [13:0] R_VAL = 14'h0003;

    logic clk_sys, sys_rst, serial_clk, serial_data, latch_strobe;
    logic prescaler_input, reference_input, shift_chain_output, modulus_select;
    logic oscillator_drive_output, vco_divided_pulse, ref_divided_pulse;
    logic control_bit_value;
    scp_ref_source_type ref_source;
    logic [9:0] n_latch_value;
    logic [6:0] a_latch_value;
    logic [13:0] r_latch_value;
    int n_fail, checked, n_vco, n_ref, pos;

    scp_port scp_port_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_data(serial_data), .latch_strobe(latch_strobe),
        .shift_chain_output(shift_chain_output), .prescaler_input(prescaler_input),
        .reference_input(reference_input), .ref_source(ref_source),
        .modulus_select(modulus_select), .oscillator_drive_output(oscillator_drive_output),
        .vco_divided_pulse(vco_divided_pulse), .ref_divided_pulse(ref_divided_pulse),
        .n_latch_value(n_latch_value), .a_latch_value(a_latch_value),
        .r_latch_value(r_latch_value), .control_bit_value(control_bit_value)
    );

    scp_host_model scp_host_model_i (
        .serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe)
    );

    // 100 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // count divided pulses
    always @(posedge clk_sys) begin
        if (vco_divided_pulse === 1'h1) n_vco++;
        if (ref_divided_pulse === 1'h1) n_ref++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one counting edge; pin held 3 high, 4 low for the synchroniser
    task automatic pin_edge(input bit on_ref);
        @(posedge clk_sys);
        if (on_ref) reference_input <= 1'h1;
        else prescaler_input <= 1'h1;
        repeat (3) @(posedge clk_sys);
        reference_input <= 1'h0;
        prescaler_input <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        n_fail = 0;
        checked = 0;
        sys_rst = 1'h1;
        prescaler_input = 1'h0;
        reference_input = 1'h0;
        ref_source = SCP_SRC_EXTERNAL;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'h0;
        // frame with spare bit set and control one
        scp_host_model_i.send_frame({1'h1, R_VAL, N_VAL, A_VAL}, 1'h1);
        repeat (4) @(posedge clk_sys);
        check(shift_chain_output, 1'h1);
        scp_host_model_i.pulse_strobe();
        check({n_latch_value, a_latch_value}, {N_VAL, A_VAL});
        check(r_latch_value, R_VAL);
        check(control_bit_value, 1'h1);
        check(shift_chain_output, 1'h1);
        // priming edge reloads, then two full divide cycles
        pin_edge(1'h0);
        n_vco = 0;
        for (int j = 1; j <= 10; j++) begin
            pin_edge(1'h0);
            pos = (j - 1) % N_VAL + 1;
            check(modulus_select, pos >= A_VAL && pos < N_VAL);
        end
        check(n_vco, 2);
        // reference divide from the external input
        pin_edge(1'h1);
        n_ref = 0;
        repeat (9) pin_edge(1'h1);
        check(n_ref, 3);
        check(oscillator_drive_output, 1'h0);
        ref_source <= SCP_SRC_OSCILLATOR;
        repeat (4) @(posedge clk_sys);
        check(oscillator_drive_output, 1'h1);
        // control zero frame: nothing moves before the strobe
        scp_host_model_i.send_frame(32'h7fff_ffff, 1'h0);
        repeat (4) @(posedge clk_sys);
        check({n_latch_value, a_latch_value}, {N_VAL, A_VAL});
        check(shift_chain_output, 1'h0);
        scp_host_model_i.pulse_strobe();
        check({n_latch_value, a_latch_value}, 17'h1_ffff);
        check(r_latch_value, R_VAL);
        check(control_bit_value, 1'h0);
        // second strobe without shifting reloads the kept word
        scp_host_model_i.pulse_strobe();
        check(a_latch_value, 7'h7f);
        // a of zero: no low-modulus part, select stays high across reloads
        scp_host_model_i.send_frame({15'h0000, 10'h003, 7'h00}, 1'h0);
        scp_host_model_i.pulse_strobe();
        check({n_latch_value, a_latch_value}, {10'h003, 7'h00});
        n_vco = 0;
        repeat (8) pin_edge(1'h0);
        check(modulus_select, 1'h1);
        check(n_vco, 2);
        report_and_stop();
    end
endmodule

`default_nettype wire
